// File: pkg/pi_ctrl_pkg.sv
/*
 * Constants for the trapezoidal PI control block: data widths, gain
 * scaling, saturation bounds, task interval timing and reset values.
 * Assumes a single 125 MHz clock drives every module that imports it.
 */
package pi_ctrl_pkg;

    // ************************************************************
    // Data widths
    // ************************************************************
    localparam int DATA_W = 16;
    localparam int WIDE_W = 40;

    // ************************************************************
    // Scaling and saturation
    // ************************************************************
    localparam logic signed [WIDE_W-1:0] SUM_GAIN_UNITY   = 40'sh00_0000_0800;
    localparam logic signed [WIDE_W-1:0] LOOP_GAIN_UNITY  = 40'sh00_0000_1000;
    localparam logic signed [WIDE_W-1:0] TRAPEZOID_DIV    = 40'sh00_0000_0064;
    localparam logic signed [WIDE_W-1:0] SAT_POS          = 40'sh00_0000_7FFF;
    localparam logic signed [WIDE_W-1:0] SAT_NEG          = -40'sh00_0000_7FFF;

    // ************************************************************
    // Task interval timing
    // ************************************************************
    localparam int CLOCK_KHZ        = 125000;
    localparam int TASK_INTERVAL_MS = 20;
    localparam int TICK_CYCLES      = TASK_INTERVAL_MS * CLOCK_KHZ;
    localparam int TICK_CNT_W       = 22;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic signed [DATA_W-1:0] RESET_SUM_GAIN  = 16'sh0800;
    localparam logic        [DATA_W-1:0] RESET_LOOP_GAIN = 16'h1000;
    localparam logic signed [DATA_W-1:0] RESET_WORD      = 16'sh0000;

endpackage

// File: design/task_tick_divider.sv
/*
 * Divides the system clock down to the periodic task interval and
 * emits a one-cycle enable pulse at the end of each interval.
 * Assumes a synchronous active-low reset on the same clock.
 */
`timescale 1ns/1ps
module task_tick_divider
    import pi_ctrl_pkg::*;
#(
    parameter int PERIOD_CYCLES = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Interval enable
    output logic      tick
);

    logic [TICK_CNT_W-1:0] count;
    logic [TICK_CNT_W-1:0] next_count;
    logic                  next_tick;

    // ************************************************************
    // Interval counter
    // ************************************************************
    always_comb begin
        next_tick  = 1'b0;
        next_count = count + 1'b1;
        if (count == TICK_CNT_W'(PERIOD_CYCLES - 1)) begin
            next_count = '0;
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule

// File: design/pi_controller_trapezoidal.sv
/*
 * Proportional-integral control block with trapezoidal integration,
 * evaluated once per task interval, with output and accumulator
 * clamping and limit flags.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module pi_controller_trapezoidal
    import pi_ctrl_pkg::*;
#(
    parameter int PERIOD_CYCLES = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     resetn,
    // Linked inputs
    input  wire logic signed [DATA_W-1:0] in_pos,
    input  wire logic signed [DATA_W-1:0] in_neg,
    input  wire logic                     set_preset,
    input  wire logic signed [DATA_W-1:0] preset,
    // Parameter inputs, captured on param_load
    input  wire logic                     param_load,
    input  wire logic signed [DATA_W-1:0] summing_gain_in,
    input  wire logic        [DATA_W-1:0] integral_gain_in,
    input  wire logic        [DATA_W-1:0] proportional_gain_in,
    input  wire logic signed [DATA_W-1:0] min_limit_in,
    input  wire logic signed [DATA_W-1:0] max_limit_in,
    // Results
    output logic signed [DATA_W-1:0]      control_out,
    output logic signed [DATA_W-1:0]      in_diff,
    output logic signed [DATA_W-1:0]      proportional_term,
    output logic signed [DATA_W-1:0]      integral_accumulator,
    output logic                          low_limit_flag,
    output logic                          high_limit_flag,
    output logic                          update_done
);

    // ************************************************************
    // Arithmetic helpers
    // ************************************************************
    function automatic logic signed [WIDE_W-1:0] clamp(
        input logic signed [WIDE_W-1:0] value,
        input logic signed [WIDE_W-1:0] lo,
        input logic signed [WIDE_W-1:0] hi
    );
        logic signed [WIDE_W-1:0] r;
        r = value;
        if (value > hi) begin
            r = hi;
        end else if (value < lo) begin
            r = lo;
        end
        return r;
    endfunction

    function automatic logic signed [WIDE_W-1:0] scale(
        input logic signed [WIDE_W-1:0] value,
        input logic signed [WIDE_W-1:0] gain,
        input logic signed [WIDE_W-1:0] unity
    );
        logic signed [WIDE_W-1:0] prod;
        prod = value * gain;
        return prod / unity;
    endfunction

    // ************************************************************
    // Task tick
    // ************************************************************
    logic tick;

    task_tick_divider #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_tick (
        .clock  (clock),
        .resetn (resetn),
        .tick   (tick)
    );

    // ************************************************************
    // Parameter registers
    // ************************************************************
    logic signed [DATA_W-1:0] summing_gain;
    logic        [DATA_W-1:0] integral_gain;
    logic        [DATA_W-1:0] proportional_gain;
    logic signed [DATA_W-1:0] min_limit;
    logic signed [DATA_W-1:0] max_limit;
    logic signed [DATA_W-1:0] next_summing_gain;
    logic        [DATA_W-1:0] next_integral_gain;
    logic        [DATA_W-1:0] next_proportional_gain;
    logic signed [DATA_W-1:0] next_min_limit;
    logic signed [DATA_W-1:0] next_max_limit;

    always_comb begin
        next_summing_gain      = summing_gain;
        next_integral_gain     = integral_gain;
        next_proportional_gain = proportional_gain;
        next_min_limit         = min_limit;
        next_max_limit         = max_limit;
        if (param_load) begin
            next_summing_gain      = summing_gain_in;
            next_integral_gain     = integral_gain_in;
            next_proportional_gain = proportional_gain_in;
            next_min_limit         = min_limit_in;
            next_max_limit         = max_limit_in;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            summing_gain      <= RESET_SUM_GAIN;
            integral_gain     <= RESET_LOOP_GAIN;
            proportional_gain <= RESET_LOOP_GAIN;
            min_limit         <= RESET_WORD;
            max_limit         <= RESET_WORD;
        end else begin
            summing_gain      <= next_summing_gain;
            integral_gain     <= next_integral_gain;
            proportional_gain <= next_proportional_gain;
            min_limit         <= next_min_limit;
            max_limit         <= next_max_limit;
        end
    end

    // ************************************************************
    // Control computation
    // ************************************************************
    logic signed [WIDE_W-1:0] diff_w;
    logic signed [WIDE_W-1:0] sum_w;
    logic signed [WIDE_W-1:0] prop_w;
    logic signed [WIDE_W-1:0] rate_w;
    logic signed [WIDE_W-1:0] acc_w;
    logic signed [WIDE_W-1:0] total_w;
    logic signed [WIDE_W-1:0] lo_w;
    logic signed [WIDE_W-1:0] hi_w;

    logic signed [DATA_W-1:0] rate_prev;
    logic signed [DATA_W-1:0] next_rate_prev;
    logic signed [DATA_W-1:0] next_control_out;
    logic signed [DATA_W-1:0] next_in_diff;
    logic signed [DATA_W-1:0] next_proportional_term;
    logic signed [DATA_W-1:0] next_integral_accumulator;
    logic                     next_low_limit_flag;
    logic                     next_high_limit_flag;

    always_comb begin
        lo_w   = WIDE_W'(min_limit);
        hi_w   = WIDE_W'(max_limit);
        diff_w = WIDE_W'(in_pos) - WIDE_W'(in_neg);
        sum_w  = clamp(scale(diff_w, WIDE_W'(summing_gain), SUM_GAIN_UNITY),
                       SAT_NEG, SAT_POS);
        prop_w = scale(sum_w, {{(WIDE_W-DATA_W){1'b0}}, proportional_gain},
                       LOOP_GAIN_UNITY);
        rate_w = scale(sum_w, {{(WIDE_W-DATA_W){1'b0}}, integral_gain},
                       LOOP_GAIN_UNITY);
        rate_w = clamp(rate_w, SAT_NEG, SAT_POS);
        if (set_preset) begin
            acc_w  = WIDE_W'(preset);
            rate_w = '0;
        end else begin
            acc_w = WIDE_W'(integral_accumulator)
                  + (rate_w + WIDE_W'(rate_prev)) / TRAPEZOID_DIV;
            acc_w = clamp(acc_w, lo_w, hi_w);
        end
        total_w = acc_w + clamp(prop_w, SAT_NEG, SAT_POS);

        next_in_diff              = in_diff;
        next_proportional_term    = proportional_term;
        next_integral_accumulator = integral_accumulator;
        next_rate_prev            = rate_prev;
        next_control_out          = control_out;
        next_low_limit_flag       = low_limit_flag;
        next_high_limit_flag      = high_limit_flag;
        if (tick) begin
            next_in_diff              = DATA_W'(clamp(diff_w, SAT_NEG, SAT_POS));
            next_proportional_term    = DATA_W'(clamp(prop_w, SAT_NEG, SAT_POS));
            next_integral_accumulator = DATA_W'(acc_w);
            next_rate_prev            = DATA_W'(rate_w);
            if (total_w > hi_w) begin
                next_control_out     = max_limit;
                next_high_limit_flag = 1'b1;
                next_low_limit_flag  = 1'b0;
            end else if (total_w < lo_w) begin
                next_control_out     = min_limit;
                next_high_limit_flag = 1'b0;
                next_low_limit_flag  = 1'b1;
            end else begin
                next_control_out     = DATA_W'(total_w);
                next_high_limit_flag = 1'b0;
                next_low_limit_flag  = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            in_diff              <= RESET_WORD;
            proportional_term    <= RESET_WORD;
            integral_accumulator <= RESET_WORD;
            rate_prev            <= RESET_WORD;
            control_out          <= RESET_WORD;
            low_limit_flag       <= 1'b0;
            high_limit_flag      <= 1'b0;
            update_done          <= 1'b0;
        end else begin
            in_diff              <= next_in_diff;
            proportional_term    <= next_proportional_term;
            integral_accumulator <= next_integral_accumulator;
            rate_prev            <= next_rate_prev;
            control_out          <= next_control_out;
            low_limit_flag       <= next_low_limit_flag;
            high_limit_flag      <= next_high_limit_flag;
            update_done          <= tick;
        end
    end

endmodule

// File: tb/pi_ctrl_props.sv
/* Port checker for the PI block: limits, preset, difference, reset.
   Assumes it is bound into pi_controller_trapezoidal. */
`timescale 1ns/1ps
module pi_ctrl_props
    import pi_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic                     clock,
    input wire logic                     resetn,
    // Inputs
    input wire logic signed [DATA_W-1:0] in_pos,
    input wire logic signed [DATA_W-1:0] in_neg,
    input wire logic                     set_preset,
    input wire logic signed [DATA_W-1:0] preset,
    input wire logic                     param_load,
    input wire logic signed [DATA_W-1:0] min_limit_in,
    input wire logic signed [DATA_W-1:0] max_limit_in,
    // Results
    input wire logic signed [DATA_W-1:0] control_out,
    input wire logic signed [DATA_W-1:0] in_diff,
    input wire logic signed [DATA_W-1:0] integral_accumulator,
    input wire logic                     low_limit_flag,
    input wire logic                     high_limit_flag,
    input wire logic                     update_done
);
    wire logic signed [16:0]       dw = in_pos - in_neg;
    logic signed      [DATA_W-1:0] mn, mx, dq, pq;
    logic                          sq;
    always_ff @(posedge clock) begin
        dq <= dw > 32767 ? 16'sh7FFF : (dw < -32767 ? -16'sh7FFF : dw[15:0]);
        pq <= preset;
        sq <= set_preset;
        if (!resetn || param_load) begin
            mn <= resetn ? min_limit_in : '0;
            mx <= resetn ? max_limit_in : '0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_pulse; update_done ##1 !update_done; endsequence
    sequence s_idle; !update_done && $past(resetn); endsequence
    property p_pulse; update_done |-> s_pulse; endproperty
    property p_hold; s_idle |-> $stable({control_out, integral_accumulator, in_diff,
        low_limit_flag, high_limit_flag}); endproperty
    property p_hi; update_done && high_limit_flag |->
        !low_limit_flag && control_out == $past(mx); endproperty
    property p_lo; update_done && low_limit_flag |->
        !high_limit_flag && control_out == $past(mn); endproperty
    property p_acc; update_done && !sq |->
        integral_accumulator >= $past(mn) && integral_accumulator <= $past(mx); endproperty
    property p_set; update_done && sq |-> integral_accumulator == pq; endproperty
    property p_diff; update_done |-> in_diff == dq; endproperty
    property p_rst; !$past(resetn) |-> !update_done && control_out == 0 &&
        integral_accumulator == 0 && !low_limit_flag && !high_limit_flag; endproperty
    a_pulse: assert property (p_pulse) else $error("done pulse too long");
    a_hold: assert property (p_hold) else $error("output moved off tick");
    a_hi: assert property (p_hi) else $error("high clamp wrong");
    a_lo: assert property (p_lo) else $error("low clamp wrong");
    a_acc: assert property (p_acc) else $error("accumulator out of bounds");
    a_set: assert property (p_set) else $error("preset not loaded");
    a_diff: assert property (p_diff) else $error("difference wrong");
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind pi_controller_trapezoidal pi_ctrl_props props_u (
    .clock(clock), .resetn(resetn), .in_pos(in_pos), .in_neg(in_neg),
    .set_preset(set_preset), .preset(preset), .param_load(param_load),
    .min_limit_in(min_limit_in), .max_limit_in(max_limit_in), .control_out(control_out),
    .in_diff(in_diff), .integral_accumulator(integral_accumulator),
    .low_limit_flag(low_limit_flag), .high_limit_flag(high_limit_flag),
    .update_done(update_done));

// File: tb/linked_source.sv
/* Model of the linked blocks that feed the PI inputs.
   Assumes source values from the bench on the same clock. */
`timescale 1ns/1ps
module linked_source
    import pi_ctrl_pkg::*;
(
    // Clock
    input  wire logic                     clock,
    // Source values
    input  wire logic signed [DATA_W-1:0] src_pos,
    input  wire logic signed [DATA_W-1:0] src_neg,
    input  wire logic                     src_set,
    input  wire logic signed [DATA_W-1:0] src_preset,
    // Linked outputs
    output logic signed [DATA_W-1:0]      in_pos,
    output logic signed [DATA_W-1:0]      in_neg,
    output logic                          set_preset,
    output logic signed [DATA_W-1:0]      preset
);
    initial begin
        {in_pos, in_neg, set_preset, preset} = '0;
    end
    // Source blocks register their outputs once a clock
    always @(posedge clock) begin
        in_pos <= src_pos;
        in_neg <= src_neg;
        set_preset <= src_set;
        preset <= src_preset;
    end
endmodule

// File: tb/pi_controller_trapezoidal_tb.sv
/* Self-checking bench for the PI block with a reference model.
   Assumes the linked source model and a short task period. */
`timescale 1ns/1ps
module pi_controller_trapezoidal_tb;
    import pi_ctrl_pkg::*;
    localparam int PER = 8;
    logic                     clock = 1'b0, resetn = 1'b0, param_load = 1'b0, s_set = 1'b0;
    logic signed [DATA_W-1:0] s_pos = '0, s_neg = '0, s_pre = '0, sg = '0, mn = '0, mx = '0;
    logic        [DATA_W-1:0] ki = '0, kp = '0;
    logic signed [DATA_W-1:0] in_pos, in_neg, preset, control_out, in_diff, prop, acc;
    logic                     set_preset, low_limit_flag, high_limit_flag, update_done;
    logic        [65:0]       exp_q[$];
    wire logic   [65:0]       got = {control_out, in_diff, prop, acc, low_limit_flag,
                                     high_limit_flag};
    bit          [31:0]       rng = 32'h56;
    int                       err_total = 0, n_tests = 0, gap = -1;
    longint                   am, rpm, gm, kim, kpm, mnm, mxm;

    always #4 clock = ~clock;

    linked_source src_u (.clock(clock), .src_pos(s_pos), .src_neg(s_neg), .src_set(s_set),
        .src_preset(s_pre), .in_pos(in_pos), .in_neg(in_neg), .set_preset(set_preset),
        .preset(preset));
    pi_controller_trapezoidal #(.PERIOD_CYCLES(PER)) dut_u (.clock(clock), .resetn(resetn),
        .in_pos(in_pos), .in_neg(in_neg), .set_preset(set_preset), .preset(preset),
        .param_load(param_load), .summing_gain_in(sg), .integral_gain_in(ki),
        .proportional_gain_in(kp), .min_limit_in(mn), .max_limit_in(mx),
        .control_out(control_out), .in_diff(in_diff), .proportional_term(prop),
        .integral_accumulator(acc), .low_limit_flag(low_limit_flag),
        .high_limit_flag(high_limit_flag), .update_done(update_done));

    function automatic longint lim(longint v, longint lo, longint hi);
        return v > hi ? hi : (v < lo ? lo : v);
    endfunction
    function automatic longint rnd(longint span);
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng % span;
    endfunction
    task automatic check(string what, logic [65:0] seen, logic [65:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        {am, rpm, mnm, mxm} = '0;
        gm = 2048;
        kim = 4096;
        kpm = 4096;
        @(posedge clock);
        check("reset state", got, 66'h0);
    endtask
    task automatic step(longint p, longint n, bit s, longint pr, bit ld);
        longint sm, pt, r, tot;
        s_pos <= 16'(p);
        s_neg <= 16'(n);
        s_set <= s;
        s_pre <= 16'(pr);
        param_load <= ld;
        if (ld) begin
            {sg, ki, kp, mn, mx} <= {16'(gm), 16'(kim), 16'(kpm), 16'(mnm), 16'(mxm)};
        end
        sm = lim(gm * (p - n) / 2048, -32767, 32767);
        pt = lim(sm * kpm / 4096, -32767, 32767);
        r = lim(sm * kim / 4096, -32767, 32767);
        if (s) begin
            am = pr;
            r = 0;
        end else begin
            am = lim(am + (r + rpm) / 100, mnm, mxm);
        end
        rpm = r;
        tot = am + pt;
        exp_q.push_back({16'(lim(tot, mnm, mxm)), 16'(lim(p - n, -32767, 32767)),
                         16'(pt), 16'(am), tot < mnm && tot <= mxm, tot > mxm});
        @(posedge clock);
        param_load <= 1'b0;
        for (int i = 0; i <= 2 * PER; i++) begin
            @(posedge clock);
            if (update_done === 1'b1) return;
        end
        err_total++;
        tally_and_finish();
    endtask

    always @(posedge clock) begin
        if (resetn !== 1'b1) gap = -1;
        else if (gap >= 0) gap++;
        if (update_done === 1'b1) begin
            if (gap > 0) check("update spacing", 66'(gap), 66'(PER));
            gap = 0;
            if (exp_q.size() == 0) check("spare update", 66'h0, 66'h1);
            else check("results", got, exp_q.pop_front());
        end
    end

    initial begin
        do_reset();
        mnm = -32767;
        mxm = 32767;
        step(0, 0, 1, -32767, 1);
        repeat (3) step(32767, 0, 0, 0, 0);
        step(32767, -32767, 0, 0, 0);
        mnm = -100;
        mxm = 100;
        repeat (3) step(-5000, 300, 0, 0, 1);
        $display("directed steps done");
        repeat (60) begin
            gm = rnd(65535) - 32767;
            kim = rnd(32768);
            kpm = rnd(32768);
            mnm = -rnd(32768);
            mxm = rnd(32768);
            step(rnd(65535) - 32767, rnd(65535) - 32767, rnd(8) == 0, rnd(65535) - 32767, 1);
        end
        $display("random steps done");
        do_reset();
        step(100, 0, 0, 0, 0);
        @(posedge clock);
        $display("reset steps done");
        tally_and_finish();
    end
endmodule
